//--- rtl/vds_top.sv
// The address map and the APB slave port were left to the implementer.
`include "vds_regs.svh"
module vds_top
    import vds_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Samples from the Y/C separator
    input wire logic in_valid,
    input wire logic in_line_start,
    input wire logic in_field_start,
    input wire logic [7:0] in_y,
    input wire logic [7:0] in_c,
    // Scaled pixels to the output port
    output logic out_valid,
    output logic [7:0] out_y,
    output logic [7:0] out_c
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Linear blend from a toward b by ph/32.
    function automatic vds_pix_t vds_lerp(input vds_pix_t a, input vds_pix_t b,
                                          input logic [4:0] ph);
        logic signed [9:0] diff;
        logic signed [15:0] prod;
        logic signed [10:0] sum;
        diff = $signed({2'b00, b}) - $signed({2'b00, a});
        prod = diff * $signed({1'b0, ph});
        sum = $signed({3'b000, a}) + 11'(prod >>> 5);
        return sum[7:0];
    endfunction : vds_lerp

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] ctrl;
    logic [7:0] horiz_ratio_upper;
    logic [7:0] horiz_ratio_lower;
    logic [15:0] vert_ratio;
    logic [4:0] vert_filter_control;
    logic [10:0] horiz_delay_count;
    logic [10:0] horiz_active_count;
    logic [10:0] vert_delay_count;
    logic [10:0] vert_active_count;
    logic [10:0] last_line_pixels;
    logic [10:0] vcnt;
    logic [31:0] next_prdata;
    logic addr_hit;

    wire apb_setup = psel & ~penable;
    wire apb_write = psel & penable & pready & pwrite;

    // Read decode happens in the setup cycle so the answer is registered.
    always_comb begin
        next_prdata = 32'h00000000;
        addr_hit = 1'b1;
        case (paddr)
            `VDS_OFF_CTRL: next_prdata = {24'h000000, ctrl};
            `VDS_OFF_HRATIO_UP: next_prdata = {24'h000000, horiz_ratio_upper};
            `VDS_OFF_HRATIO_LO: next_prdata = {24'h000000, horiz_ratio_lower};
            `VDS_OFF_VRATIO: next_prdata = {16'h0000, vert_ratio};
            `VDS_OFF_VFILT: next_prdata = {27'h0000000, vert_filter_control};
            `VDS_OFF_HDLY: next_prdata = {21'h000000, horiz_delay_count};
            `VDS_OFF_HACT: next_prdata = {21'h000000, horiz_active_count};
            `VDS_OFF_VDLY: next_prdata = {21'h000000, vert_delay_count};
            `VDS_OFF_VACT: next_prdata = {21'h000000, vert_active_count};
            `VDS_OFF_STATUS: next_prdata = {5'h00, vcnt, 5'h00, last_line_pixels};
            default: addr_hit = 1'b0;
        endcase
    end

    // One wait-free access phase: pready rises for the cycle after setup.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= apb_setup;
            pslverr <= apb_setup & ~addr_hit;
            prdata <= (apb_setup & ~pwrite) ? next_prdata : 32'h00000000;
        end
    end

    // Writes land on the completing edge only.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= `VDS_RST_CTRL;
            horiz_ratio_upper <= `VDS_RST_HRATIO;
            horiz_ratio_lower <= `VDS_RST_HRATIO;
            vert_ratio <= `VDS_RST_VRATIO;
            vert_filter_control <= `VDS_RST_VFILT;
            horiz_delay_count <= `VDS_RST_COUNT;
            horiz_active_count <= `VDS_RST_COUNT;
            vert_delay_count <= `VDS_RST_COUNT;
            vert_active_count <= `VDS_RST_COUNT;
        end else if (apb_write) begin
            case (paddr)
                `VDS_OFF_CTRL: ctrl <= pwdata[7:0];
                `VDS_OFF_HRATIO_UP: horiz_ratio_upper <= pwdata[7:0];
                `VDS_OFF_HRATIO_LO: horiz_ratio_lower <= pwdata[7:0];
                `VDS_OFF_VRATIO: vert_ratio <= pwdata[15:0];
                `VDS_OFF_VFILT: vert_filter_control <= pwdata[4:0];
                `VDS_OFF_HDLY: horiz_delay_count <= pwdata[10:0];
                `VDS_OFF_HACT: horiz_active_count <= pwdata[10:0];
                `VDS_OFF_VDLY: vert_delay_count <= pwdata[10:0];
                `VDS_OFF_VACT: vert_active_count <= pwdata[10:0];
                default: ;
            endcase
        end
    end

    // Each data-reduction mechanism has its own enable.
    wire horiz_en = ctrl[`VDS_CTRL_HEN];
    wire vert_en = ctrl[`VDS_CTRL_VEN];
    wire crop_en = ctrl[`VDS_CTRL_CROP];
    wire comb_en = ctrl[`VDS_CTRL_COMB];
    wire [15:0] horiz_ratio = {horiz_ratio_upper, horiz_ratio_lower};
    wire noninterlaced_select = vert_filter_control[`VDS_VFILT_NONINT];

    // The ratio word is negative; its negation is the line step in 1/512ths.
    logic [12:0] vstep_raw;
    logic [12:0] vstep_cap;
    logic [12:0] vstep;
    always_comb begin
        vstep_raw = 13'h0000 - vert_ratio[12:0];
        vstep_cap = noninterlaced_select ? `VDS_VSTEP_MAX_FRAME : `VDS_VSTEP_MAX;
        vstep = (vstep_raw > vstep_cap) ? vstep_cap : vstep_raw;
    end

    // ------------------------------------------------------------
    // Stage 0: capture, line store read, per-line decisions
    // ------------------------------------------------------------
    logic [10:0] col;
    logic [10:0] rd_addr;
    logic [39:0] rd_data;
    logic [13:0] vacc;
    logic [13:0] vacc_now;
    logic [10:0] vline_now;
    logic line_emit;
    logic line_vwin;
    logic line_fresh;
    logic [4:0] line_frac;
    logic s0_v;
    logic s0_first;
    logic [10:0] s0_col;
    vds_pix_t s0_y;
    vds_pix_t s0_c;

    assign rd_addr = in_line_start ? 11'h000 : col;

    // Input samples come from logic on pclk, so no synchroniser is needed.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            col <= 11'h000;
            s0_v <= 1'b0;
            s0_first <= 1'b0;
            s0_col <= 11'h000;
            s0_y <= 8'h00;
            s0_c <= 8'h00;
        end else begin
            s0_v <= in_valid;
            s0_first <= in_valid & in_line_start;
            if (in_valid) begin
                col <= rd_addr + 11'h001;
                s0_col <= rd_addr;
                s0_y <= in_y;
                s0_c <= in_c;
            end
        end
    end

    // Vertical position: a line is kept when the accumulator is below one line.
    always_comb begin
        vacc_now = in_field_start ? 14'h0000 : vacc;
        vline_now = in_field_start ? 11'h000 : vcnt + 11'h001;
    end

    // Vertical window counts input lines, before any vertical scaling.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vacc <= 14'h0000;
            vcnt <= 11'h000;
            line_emit <= 1'b1;
            line_vwin <= 1'b1;
            line_fresh <= 1'b1;
            line_frac <= 5'h00;
        end else if (in_valid & in_line_start) begin
            vcnt <= vline_now;
            line_fresh <= in_field_start;
            line_frac <= vacc_now[8:4];
            line_emit <= ~vert_en | (vacc_now < `VDS_VUNIT);
            if (vacc_now < `VDS_VUNIT) begin
                vacc <= vacc_now + {1'b0, vstep};
            end else begin
                vacc <= vacc_now - `VDS_VUNIT;
            end
            line_vwin <= ~crop_en | ((vline_now >= vert_delay_count) &
                (vline_now < vert_delay_count + vert_active_count));
        end
    end

    // ------------------------------------------------------------
    // Stage 1: vertical filter and interpolation
    // ------------------------------------------------------------
    logic [39:0] hist;
    logic [11:0] lp_sum;
    vds_pix_t lp;
    vds_pix_t vi;
    vds_pix_t yv;
    vds_pix_t cv;
    logic [9:0] blend;
    logic [8:0] cavg;

    // A field's first line has no history, so it stands in for older lines.
    assign hist = line_fresh ? {s0_c, {4{s0_y}}} : rd_data;

    vds_line_mem u_line_mem (
        .clk(pclk),
        .rst_n(presetn),
        .wr_en(s0_v),
        .wr_addr(s0_col),
        .wr_data({s0_c, hist[23:0], s0_y}),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    // Binomial low-pass of 2 to 5 lines, then blended with the interpolation.
    always_comb begin
        case (vds_taps_t'(vert_filter_control[`VDS_VFILT_TAPS]))
            VDS_TAPS_2: lp_sum = 12'({s0_y} + {hist[7:0]}) << 3;
            VDS_TAPS_3: lp_sum = (12'(s0_y) + 12'({hist[7:0], 1'b0}) +
                12'(hist[15:8])) << 2;
            VDS_TAPS_4: lp_sum = (12'(s0_y) + 12'(hist[7:0]) * 12'h003 +
                12'(hist[15:8]) * 12'h003 + 12'(hist[23:16])) << 1;
            default: lp_sum = 12'(s0_y) + 12'(hist[7:0]) * 12'h004 +
                12'(hist[15:8]) * 12'h006 + 12'(hist[23:16]) * 12'h004 +
                12'(hist[31:24]);
        endcase
        lp = lp_sum[11:4];
        vi = vds_lerp(hist[7:0], s0_y, line_frac);
        case (vert_filter_control[`VDS_VFILT_OPT])
            2'h0: blend = {vi, 2'b00};
            2'h1: blend = 10'(vi) * 10'h003 + 10'(lp);
            2'h2: blend = {9'(vi) + 9'(lp), 1'b0};
            default: blend = {lp, 2'b00};
        endcase
        yv = vert_en ? blend[9:2] : s0_y;
        cavg = 9'(s0_c) + 9'(hist[39:32]);
        cv = (vert_en & comb_en) ? cavg[8:1] : s0_c;
    end

    logic s1_v;
    logic s1_first;
    logic s1_vwin;
    vds_pix_t s1_y;
    vds_pix_t s1_c;

    // Dropped lines never reach the horizontal stage.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_v <= 1'b0;
            s1_first <= 1'b0;
            s1_vwin <= 1'b0;
            s1_y <= 8'h00;
            s1_c <= 8'h00;
        end else begin
            s1_v <= s0_v & line_emit;
            s1_first <= s0_first & line_emit;
            s1_vwin <= line_vwin;
            if (s0_v) begin
                s1_y <= yv;
                s1_c <= cv;
            end
        end
    end

    // ------------------------------------------------------------
    // Stage 2: pre-filter and horizontal poly-phase scaling
    // ------------------------------------------------------------
    vds_pix_t yh1;
    vds_pix_t yh2;
    vds_pix_t yh3;
    vds_pix_t ch1;
    vds_pix_t ch2;
    vds_pix_t pfp;
    vds_pix_t pf;
    logic [9:0] pf_sum;
    logic [16:0] hacc;
    logic [16:0] hacc_now;
    logic hemit;
    logic [4:0] hphase;

    // The pre-filter trades horizontal detail for less aliasing when shrinking.
    always_comb begin
        case (vds_pref_t'(ctrl[`VDS_CTRL_PREF]))
            VDS_PREF_OFF: pf_sum = {s1_y, 2'b00};
            VDS_PREF_121: pf_sum = 10'(s1_y) + 10'({yh1, 1'b0}) + 10'(yh2);
            VDS_PREF_11: pf_sum = {9'(s1_y) + 9'(yh1), 1'b0};
            default: pf_sum = 10'(s1_y) + 10'(yh1) + 10'(yh2) + 10'(yh3);
        endcase
        pf = pf_sum[9:2];
        hacc_now = s1_first ? 17'h00000 : hacc;
        hemit = ~horiz_en | (hacc_now < `VDS_HUNIT);
        hphase = horiz_en ? hacc_now[11:7] : 5'h00;
    end

    // Accumulator: an output adds the ratio, a skipped input removes one unit.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hacc <= 17'h00000;
        end else if (s1_v) begin
            if (hacc_now < `VDS_HUNIT) begin
                hacc <= hacc_now + {1'b0, horiz_ratio};
            end else begin
                hacc <= hacc_now - `VDS_HUNIT;
            end
        end
    end

    // Sample history restarts from each line's first sample; only that first sample is still pre-filtered with the previous line's tail.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            yh1 <= 8'h00;
            yh2 <= 8'h00;
            yh3 <= 8'h00;
            ch1 <= 8'h00;
            ch2 <= 8'h00;
            pfp <= 8'h00;
        end else if (s1_v) begin
            yh1 <= s1_y;
            yh2 <= s1_first ? s1_y : yh1;
            yh3 <= s1_first ? s1_y : yh2;
            ch1 <= s1_c;
            ch2 <= s1_first ? s1_c : ch1;
            pfp <= pf;
        end
    end

    logic s2_v;
    logic s2_line;
    logic s2_vwin;
    vds_pix_t s2_y;
    vds_pix_t s2_c;

    // Chroma is interleaved, so its neighbour of the same component is two back.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s2_v <= 1'b0;
            s2_line <= 1'b0;
            s2_vwin <= 1'b0;
            s2_y <= 8'h00;
            s2_c <= 8'h00;
        end else begin
            s2_v <= s1_v & hemit;
            s2_line <= s1_first;
            s2_vwin <= s1_vwin;
            if (s1_v) begin
                s2_y <= vds_lerp(pf, s1_first ? pf : pfp, hphase);
                s2_c <= vds_lerp(s1_c, s1_first ? s1_c : ch2, hphase);
            end
        end
    end

    // ------------------------------------------------------------
    // Stage 3: peaking, horizontal window, output
    // ------------------------------------------------------------
    logic [10:0] hcnt;
    logic [10:0] hidx;
    logic hwin;
    vds_pix_t ypo;
    logic signed [9:0] pdiff;
    logic signed [10:0] peak;
    vds_pix_t ypk;

    // Peaking adds a scaled first difference; the gain is 0, 1/4, 1/2 or 1.
    always_comb begin
        pdiff = $signed({2'b00, s2_y}) - $signed({2'b00, ypo});
        case (ctrl[`VDS_CTRL_PEAK])
            2'h0: peak = 11'sh000;
            2'h1: peak = 11'(pdiff >>> 2);
            2'h2: peak = 11'(pdiff >>> 1);
            default: peak = 11'(pdiff);
        endcase
        peak = peak + $signed({3'b000, s2_y});
        if (peak < 0) begin
            ypk = 8'h00;
        end else if (peak > 11'sh0FF) begin
            ypk = 8'hFF;
        end else begin
            ypk = peak[7:0];
        end
        hidx = s2_line ? 11'h000 : hcnt;
        hwin = ~crop_en | ((hidx >= horiz_delay_count) &
            (hidx < horiz_delay_count + horiz_active_count));
    end

    // Horizontal window counts scaled pixels; the count also shows in status.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hcnt <= 11'h000;
            last_line_pixels <= 11'h000;
            ypo <= 8'h00;
        end else begin
            if (s2_line) begin
                last_line_pixels <= hcnt;
            end
            if (s2_v) begin
                hcnt <= hidx + 11'h001;
                ypo <= s2_y;
            end else if (s2_line) begin
                hcnt <= 11'h000;
            end
        end
    end

    // All outputs come straight from flops; pixel data hold until the next valid pixel.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_valid <= 1'b0;
            out_y <= 8'h00;
            out_c <= 8'h00;
        end else begin
            out_valid <= s2_v & hwin & s2_vwin;
            if (s2_v & hwin & s2_vwin) begin
                out_y <= ypk;
                out_c <= s2_c;
            end
        end
    end

endmodule : vds_top

//--- rtl/vds_regs.svh
`ifndef VDS_REGS_SVH
`define VDS_REGS_SVH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define VDS_OFF_CTRL 8'h00
`define VDS_OFF_HRATIO_UP 8'h04
`define VDS_OFF_HRATIO_LO 8'h08
`define VDS_OFF_VRATIO 8'h0C
`define VDS_OFF_VFILT 8'h10
`define VDS_OFF_HDLY 8'h14
`define VDS_OFF_HACT 8'h18
`define VDS_OFF_VDLY 8'h1C
`define VDS_OFF_VACT 8'h20
`define VDS_OFF_STATUS 8'h24

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define VDS_CTRL_PEAK 1:0
`define VDS_CTRL_PREF 3:2
`define VDS_CTRL_HEN 4
`define VDS_CTRL_VEN 5
`define VDS_CTRL_CROP 6
`define VDS_CTRL_COMB 7
`define VDS_VFILT_TAPS 1:0
`define VDS_VFILT_OPT 3:2
`define VDS_VFILT_NONINT 4

// ------------------------------------------------------------
// Reset values
// ------------------------------------------------------------
`define VDS_RST_CTRL 8'h00
`define VDS_RST_HRATIO 8'h00
`define VDS_RST_VRATIO 16'h0000
`define VDS_RST_VFILT 5'h10
`define VDS_RST_COUNT 11'h000

// ------------------------------------------------------------
// Scaling constants
// ------------------------------------------------------------
`define VDS_HUNIT 17'h01000
`define VDS_VUNIT 14'h0200
`define VDS_VSTEP_MAX 13'h1E00
`define VDS_VSTEP_MAX_FRAME 13'h0E00

`endif

//--- rtl/vds_pkg.sv
package vds_pkg;

    // Eight-bit video sample.
    typedef logic [7:0] vds_pix_t;

    // Vertical luma filter length.
    typedef enum logic [1:0] {
        VDS_TAPS_2 = 2'h0,
        VDS_TAPS_3 = 2'h1,
        VDS_TAPS_4 = 2'h2,
        VDS_TAPS_5 = 2'h3
    } vds_taps_t;

    // Horizontal luma pre-filter choice.
    typedef enum logic [1:0] {
        VDS_PREF_OFF = 2'h0,
        VDS_PREF_121 = 2'h1,
        VDS_PREF_11 = 2'h2,
        VDS_PREF_1111 = 2'h3
    } vds_pref_t;

endpackage : vds_pkg

//--- rtl/vds_line_mem.sv
module vds_line_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Write port
    input wire logic wr_en,
    input wire logic [10:0] wr_addr,
    input wire logic [39:0] wr_data,
    // Read port
    input wire logic [10:0] rd_addr,
    output logic [39:0] rd_data
);

    logic [39:0] mem [0:2047];

    // The array has no reset; the caller masks its first reads.
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // Registered read, one cycle of latency.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= 40'h0000000000;
        end else begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule : vds_line_mem

//--- test/vds_props.sv
module vds_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Video
    input wire logic in_valid,
    input wire logic out_valid,
    input wire logic [7:0] out_y,
    input wire logic [7:0] out_c
);
    timeunit 1ns;
    timeprecision 100ps;
    // ----
    // Bus and stream checks
    // ----
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence access_s;
        psel && penable && pready;
    endsequence
    // A zero-wait slave must answer in the cycle after setup, once only.
    setup_ack_a: assert property (setup_s |=> access_s) else $error("no ready after setup");
    ready_pulse_a: assert property (pready |=> !pready) else $error("ready held");
    ready_cause_a: assert property (pready |-> $past(psel && !penable)) else $error("stray ready");
    err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
    idle_data_a: assert property (!pready |-> prdata == 32'h0) else $error("idle data");
    err_data_a: assert property (pslverr |-> prdata == 32'h0) else $error("error data");
    // Each pixel needs a sample four edges back; data only moves with a pixel.
    out_cause_a: assert property (out_valid |-> $past(in_valid, 4)) else $error("no cause");
    y_hold_a: assert property (!out_valid |-> $stable(out_y)) else $error("luma moved");
    c_hold_a: assert property (!out_valid |-> $stable(out_c)) else $error("chroma moved");
endmodule : vds_props

bind vds_top vds_props u_props (.pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr,
    .in_valid, .out_valid, .out_y, .out_c);

//--- test/vds_video_peer.sv
module vds_video_peer (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Samples towards the scaler
    output logic in_valid,
    output logic in_line_start,
    output logic in_field_start,
    output logic [7:0] in_y,
    output logic [7:0] in_c,
    // Pixels from the scaler
    input wire logic out_valid,
    input wire logic [7:0] out_y,
    input wire logic [7:0] out_c,
    output int out_count,
    output logic [7:0] last_y,
    output logic [7:0] last_c
);
    timeunit 1ns;
    timeprecision 100ps;
    // Quiet source at time zero.
    initial {in_valid, in_line_start, in_field_start, in_y, in_c} = '0;
    // The output port never stalls, so it just counts and keeps the newest luma and chroma.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_count <= 0;
        end else if (out_valid) begin
            out_count <= out_count + 1;
            last_y <= out_y;
            last_c <= out_c;
        end
    end
    // One line of a luma ramp; idle luma is inverted so stale samples never match.
    task automatic send_line(input int len, input bit first);
        for (int i = 0; i < len; i++) begin
            in_valid <= 1'b1;
            in_line_start <= (i == 0);
            in_field_start <= first && (i == 0);
            in_y <= i[7:0];
            in_c <= ~i[7:0];
            @(posedge pclk);
        end
        in_valid <= 1'b0;
        in_y <= ~in_y;
        repeat (6) @(posedge pclk);
    endtask : send_line
endmodule : vds_video_peer

//--- test/video_downscaler_tb.sv
`include "vds_regs.svh"
module video_downscaler_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err, in_valid, in_line_start, in_field_start, out_valid;
    logic [7:0] in_y, in_c, out_y, out_c, last_y, last_c;
    int out_count, n0;
    int fail_count = 0;
    int tests_run = 0;
    int cycles = 0;
    vds_top i_dut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
        .pslverr, .in_valid, .in_line_start, .in_field_start, .in_y, .in_c, .out_valid, .out_y,
        .out_c);
    vds_video_peer u_peer (.pclk, .presetn, .in_valid, .in_line_start, .in_field_start, .in_y,
        .in_c, .out_valid, .out_y, .out_c, .out_count, .last_y, .last_c);
    // 40 MHz clock.
    initial forever #12.5 pclk = ~pclk;
    // ----
    // Shared tasks
    // ----
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    // One bus transfer; the idle edge at the end keeps back-to-back calls apart.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb
    task automatic line_count(input int len, input int lines, input logic [31:0] exp);
        n0 = out_count;
        for (int l = 0; l < lines; l++) u_peer.send_line(len, l == 0);
        check(32'(out_count - n0), exp);
    endtask : line_count
    // ----
    // Scenarios
    // ----
    task automatic t_regs();
        apb(0, `VDS_OFF_VFILT, 0);
        check(rd, 32'h10);
        apb(1, 8'h28, 32'hFF);
        check({31'h0, err}, 32'h1);
        apb(0, 8'h28, 0);
        check({rd[30:0], err}, 32'h1);
        apb(1, `VDS_OFF_VRATIO, 32'hFA00);
        apb(0, `VDS_OFF_VRATIO, 0);
        check(rd, 32'hFA00);
        apb(1, `VDS_OFF_HRATIO_UP, 32'h3C);
        apb(1, `VDS_OFF_HRATIO_LO, 32'hF2);
        apb(0, `VDS_OFF_HRATIO_UP, 0);
        check(rd, 32'h3C);
        apb(0, `VDS_OFF_HRATIO_LO, 0);
        check(rd, 32'hF2);
    endtask : t_regs
    // Every peaking, pre-filter, tap and vertical option code.
    task automatic t_fields();
        for (int i = 0; i < 4; i++) begin
            apb(1, `VDS_OFF_CTRL, 32'(i * 5));
            apb(0, `VDS_OFF_CTRL, 0);
            check(rd, 32'(i * 5));
            apb(1, `VDS_OFF_VFILT, 32'(i * 5 + 16));
            apb(0, `VDS_OFF_VFILT, 0);
            check(rd, 32'(i * 5 + 16));
        end
    endtask : t_fields
    // Unscaled NTSC passes samples through; full peaking adds the ramp step, [1 1] averages.
    task automatic t_unscaled();
        apb(1, `VDS_OFF_CTRL, 32'h0);
        line_count(910, 1, 32'd910);
        check({24'h0, last_y}, 32'h8D);
        check({24'h0, last_c}, 32'h72);
        apb(1, `VDS_OFF_CTRL, 32'h3);
        line_count(910, 1, 32'd910);
        check({24'h0, last_y}, 32'h8E);
        apb(1, `VDS_OFF_CTRL, 32'h8);
        line_count(910, 1, 32'd910);
        check({24'h0, last_y}, 32'h8C);
    endtask : t_unscaled
    // PAL QCIF, 2:1 and 4:1 from (in/out - 1) * 4096; 2:1 and 4:1 on 910-sample lines.
    task automatic t_horiz();
        apb(1, `VDS_OFF_CTRL, 32'h10);
        apb(1, `VDS_OFF_HRATIO_UP, 32'h3C);
        apb(1, `VDS_OFF_HRATIO_LO, 32'hF2);
        line_count(1135, 1, 32'd237);
        apb(1, `VDS_OFF_HRATIO_LO, 32'h00);
        apb(1, `VDS_OFF_HRATIO_UP, 32'h10);
        line_count(910, 1, 32'd455);
        apb(1, `VDS_OFF_HRATIO_UP, 32'h30);
        line_count(910, 1, 32'd228);
    endtask : t_horiz
    // Both fields: 2:1 keeps every other line and 16:1 is held to 8:1; one field is not.
    task automatic t_vert();
        apb(1, `VDS_OFF_CTRL, 32'h20);
        apb(1, `VDS_OFF_VFILT, 32'h13);
        apb(1, `VDS_OFF_VRATIO, 32'h1E00);
        line_count(8, 4, 32'd16);
        apb(1, `VDS_OFF_VRATIO, 32'h0200);
        line_count(8, 9, 32'd16);
        apb(1, `VDS_OFF_VFILT, 32'h03);
        line_count(8, 9, 32'd8);
        apb(1, `VDS_OFF_VRATIO, 32'h1A00);
        line_count(8, 8, 32'd16);
    endtask : t_vert
    // Horizontal window in scaled pixels, vertical window in input lines.
    task automatic t_crop();
        apb(1, `VDS_OFF_CTRL, 32'h50);
        apb(1, `VDS_OFF_HRATIO_UP, 32'h10);
        apb(1, `VDS_OFF_HDLY, 32'd2);
        apb(1, `VDS_OFF_HACT, 32'd4);
        apb(1, `VDS_OFF_VDLY, 32'd1);
        apb(1, `VDS_OFF_VACT, 32'd1);
        line_count(16, 3, 32'd4);
    endtask : t_crop
    task automatic tally_and_finish();
        $display("comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : tally_and_finish
    // A hung handshake cannot stall the run past a few times its expected length.
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fail_count++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_regs();
        t_fields();
        t_unscaled();
        t_horiz();
        t_vert();
        t_crop();
        tally_and_finish();
    end
endmodule : video_downscaler_tb
